/* File: verilog/scd_pkg.sv */
package scd_pkg;
   // =========================================================
   // rates and decimation
   localparam int unsigned SCD_MOD_RATE_HZ = 32768;
   localparam int unsigned SCD_DEC_MULT = 8;
   localparam int unsigned SCD_STEP_TIME_NS = 244000;
   localparam logic [7:0] SCD_DEC_MIN = 8'h03;
   localparam logic [7:0] SCD_DEC_MAX = 8'hff;
   localparam logic [7:0] SCD_DEC_RST = 8'h45;
   localparam int unsigned SCD_CNT_W = 11;
   localparam int unsigned SCD_RES_W = 34;
   // =========================================================
   // settling
   localparam logic [1:0] SCD_SETTLE_CONV = 2'h3;
   localparam logic [2:0] SCD_UNSYNC_CONV = 3'h4;
   // =========================================================
   // register map (byte addresses)
   localparam logic [4:0] SCD_REG_DEC = 5'h00;
   localparam logic [4:0] SCD_REG_CTRL = 5'h04;
   localparam logic [4:0] SCD_REG_STAT = 5'h08;
   localparam logic [4:0] SCD_REG_RES_LO = 5'h0c;
   localparam logic [4:0] SCD_REG_RES_HI = 5'h10;
   localparam int unsigned SCD_CTRL_CHOP_OFF = 0;
   localparam int unsigned SCD_CTRL_CHAN_LSB = 4;
   localparam int unsigned SCD_CHAN_W = 4;
   localparam logic SCD_CHOP_OFF_RST = 1'b1;
   localparam logic [3:0] SCD_CHAN_RST = 4'h0;
   localparam int unsigned SCD_STAT_READY = 0;
   localparam int unsigned SCD_STAT_SETTLED = 1;
   localparam int unsigned SCD_STAT_ACCURATE = 2;
   localparam int unsigned SCD_STAT_CNT_LSB = 4;
   // =========================================================
   // control states
   typedef enum logic [1:0] {
      SCD_ST_OFF,
      SCD_ST_SETTLE,
      SCD_ST_RUN
   } scd_state_t;
endpackage

/* File: verilog/scd_sinc3.sv */
`timescale 1ns/10ps
`default_nettype none
module scd_sinc3 #(
   parameter int unsigned W = 34
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_restart,
   input wire logic i_sample_valid,
   input wire logic i_sample_bit,
   input wire logic i_dump,
   output logic [W-1:0] o_value
);
   // =========================================================
   // integrators and combs
   // wrap-around arithmetic is intended: the combs undo integrator overflow
   logic [W-1:0] int_q [3];
   logic [W-1:0] int_d [3];
   logic [W-1:0] dly_q [3];
   logic [W-1:0] dly_d [3];
   logic [W-1:0] comb [4];
   logic [W-1:0] out_q;
   logic [W-1:0] out_d;

   always_comb begin
      // a dump always comes with a sample, so the comb takes the integrator value
      // that already holds it; the third dump after a restart then sees no
      // sample from before the restart
      comb[0] = int_q[2] + int_q[1];
      for (int k = 0; k < 3; k++) begin
         comb[k+1] = comb[k] - dly_q[k];
      end
      for (int k = 0; k < 3; k++) begin
         int_d[k] = int_q[k];
         dly_d[k] = dly_q[k];
      end
      out_d = out_q;
      if (i_restart) begin
         for (int k = 0; k < 3; k++) begin
            int_d[k] = '0;
            dly_d[k] = '0;
         end
      end else if (i_sample_valid) begin
         int_d[0] = int_q[0] + {{(W-1){1'b0}}, i_sample_bit};
         int_d[1] = int_q[1] + int_q[0];
         int_d[2] = int_q[2] + int_q[1];
         if (i_dump) begin
            for (int k = 0; k < 3; k++) begin
               dly_d[k] = comb[k];
            end
            out_d = comb[3];
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < 3; k++) begin
            int_q[k] <= '0;
            dly_q[k] <= '0;
         end
         out_q <= '0;
      end else begin
         int_q <= int_d;
         dly_q <= dly_d;
         out_q <= out_d;
      end
   end

   assign o_value = out_q;
endmodule
`default_nettype wire

/* File: verilog/scd_decimator.sv */
`timescale 1ns/10ps
`default_nettype none
module scd_decimator
   import scd_pkg::*;
#(
   parameter int unsigned RES_W = SCD_RES_W
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_mod_valid,
   input wire logic i_mod_bit,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic [SCD_CHAN_W-1:0] o_channel,
   output logic o_chop_off,
   output logic [RES_W-1:0] o_result,
   output logic o_result_valid
);
   // =========================================================
   // bus slave timing
   // every access is answered with exactly one wait cycle, so read data
   // are registered and stable when waitrequest drops
   logic ack_q;
   logic ack_d;
   logic req;
   logic wr_now;
   logic rd_now;

   assign req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~ack_q;
   assign wr_now = i_avs_write & ack_q;
   assign rd_now = i_avs_read & ack_q;

   always_comb begin
      ack_d = req & ~ack_q;
   end

   // =========================================================
   // software-visible configuration
   logic [7:0] dec_q;
   logic [7:0] dec_d;
   logic chop_off_q;
   logic chop_off_d;
   logic [SCD_CHAN_W-1:0] chan_q;
   logic [SCD_CHAN_W-1:0] chan_d;
   logic sync_change;
   logic [7:0] wr_word;

   assign wr_word = i_avs_writedata[7:0];

   always_comb begin
      dec_d = dec_q;
      chop_off_d = chop_off_q;
      chan_d = chan_q;
      sync_change = 1'b0;
      if (wr_now && i_avs_byteenable[0]) begin
         if (i_avs_address == SCD_REG_DEC) begin
            // out-of-range words are clamped to the lowest legal value
            dec_d = (wr_word < SCD_DEC_MIN) ? SCD_DEC_MIN : wr_word;
            sync_change = 1'b1;
         end else if (i_avs_address == SCD_REG_CTRL) begin
            chop_off_d = wr_word[SCD_CTRL_CHOP_OFF];
            chan_d = wr_word[SCD_CTRL_CHAN_LSB +: SCD_CHAN_W];
            sync_change = 1'b1;
         end
      end
   end

   // =========================================================
   // decimation counter
   logic [SCD_CNT_W-1:0] cnt_q;
   logic [SCD_CNT_W-1:0] cnt_d;
   logic [SCD_CNT_W-1:0] dec_len;
   logic dump;
   logic filt_restart;

   // one word step is eight modulator samples, i.e. 0.244 ms at 32.768 kHz
   assign dec_len = SCD_CNT_W'(SCD_DEC_MULT) * {3'h0, dec_q};
   assign dump = i_mod_valid && chop_off_q && (cnt_q == dec_len - 1'b1);
   assign filt_restart = sync_change | ~chop_off_q;

   always_comb begin
      cnt_d = cnt_q;
      if (filt_restart) begin
         cnt_d = '0;
      end else if (i_mod_valid) begin
         cnt_d = dump ? '0 : cnt_q + 1'b1;
      end
   end

   logic [RES_W-1:0] filt_value;

   scd_sinc3 #(
      .W(RES_W)
   ) u_sinc3 (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_restart(filt_restart),
      .i_sample_valid(i_mod_valid),
      .i_sample_bit(i_mod_bit),
      .i_dump(dump),
      .o_value(filt_value)
   );

   // =========================================================
   // settling control
   // the filter value of a dump appears one edge later, so release is
   // decided on the dump and the result is taken on the following edge
   scd_state_t state_q;
   scd_state_t state_d;
   logic [1:0] settle_q;
   logic [1:0] settle_d;
   logic [2:0] conv_q;
   logic [2:0] conv_d;
   logic take_q;
   logic take_d;

   always_comb begin
      state_d = state_q;
      settle_d = settle_q;
      conv_d = conv_q;
      take_d = 1'b0;
      if (filt_restart) begin
         settle_d = '0;
         conv_d = '0;
         state_d = chop_off_d ? SCD_ST_SETTLE : SCD_ST_OFF;
         if (!chop_off_q && chop_off_d) begin
            state_d = SCD_ST_SETTLE;
         end
      end else begin
         unique case (state_q)
            SCD_ST_OFF: begin
               if (chop_off_q) begin
                  state_d = SCD_ST_SETTLE;
               end
            end
            SCD_ST_SETTLE: begin
               if (dump) begin
                  settle_d = settle_q + 1'b1;
                  // the first two dumps carry an unsettled result
                  if (settle_q == SCD_SETTLE_CONV - 2'h1) begin
                     state_d = SCD_ST_RUN;
                     take_d = 1'b1;
                  end
               end
            end
            SCD_ST_RUN: begin
               // no means to see an input step: every conversion is output
               take_d = dump;
               if (dump && conv_q != SCD_UNSYNC_CONV) begin
                  conv_d = conv_q + 1'b1;
               end
            end
         endcase
      end
   end

   // =========================================================
   // result register and ready flag
   logic [RES_W-1:0] res_q;
   logic [RES_W-1:0] res_d;
   logic res_vld_q;
   logic res_vld_d;
   logic ready_q;
   logic ready_d;

   always_comb begin
      res_d = res_q;
      res_vld_d = take_q;
      ready_d = ready_q;
      if (rd_now && i_avs_address == SCD_REG_RES_LO) begin
         ready_d = 1'b0;
      end
      if (filt_restart) begin
         ready_d = 1'b0;
      end
      if (take_q) begin
         res_d = filt_value;
         ready_d = 1'b1;
      end
   end

   // =========================================================
   // read data
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   always_comb begin
      rdata_d = rdata_q;
      if (req && !ack_q) begin
         rdata_d = '0;
         unique case (i_avs_address)
            SCD_REG_DEC: rdata_d[7:0] = dec_q;
            SCD_REG_CTRL: begin
               rdata_d[SCD_CTRL_CHOP_OFF] = chop_off_q;
               rdata_d[SCD_CTRL_CHAN_LSB +: SCD_CHAN_W] = chan_q;
            end
            SCD_REG_STAT: begin
               rdata_d[SCD_STAT_READY] = ready_q;
               rdata_d[SCD_STAT_SETTLED] = (state_q == SCD_ST_RUN);
               rdata_d[SCD_STAT_ACCURATE] = (conv_q == SCD_UNSYNC_CONV);
               rdata_d[SCD_STAT_CNT_LSB +: 3] = conv_q;
            end
            SCD_REG_RES_LO: rdata_d = res_q[31:0];
            SCD_REG_RES_HI: rdata_d[RES_W-33:0] = res_q[RES_W-1:32];
            default: rdata_d = '0;
         endcase
      end
   end

   // =========================================================
   // state registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ack_q <= 1'b0;
         dec_q <= SCD_DEC_RST;
         chop_off_q <= SCD_CHOP_OFF_RST;
         chan_q <= SCD_CHAN_RST;
         cnt_q <= '0;
         state_q <= SCD_ST_OFF;
         settle_q <= '0;
         conv_q <= '0;
         take_q <= 1'b0;
         res_q <= '0;
         res_vld_q <= 1'b0;
         ready_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q <= ack_d;
         dec_q <= dec_d;
         chop_off_q <= chop_off_d;
         chan_q <= chan_d;
         cnt_q <= cnt_d;
         state_q <= state_d;
         settle_q <= settle_d;
         conv_q <= conv_d;
         take_q <= take_d;
         res_q <= res_d;
         res_vld_q <= res_vld_d;
         ready_q <= ready_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_avs_readdata = rdata_q;
   assign o_channel = chan_q;
   assign o_chop_off = chop_off_q;
   assign o_result = res_q;
   assign o_result_valid = res_vld_q;
endmodule
`default_nettype wire

/* File: verification/scd_mod_model.sv */
`timescale 1ns/10ps
`default_nettype none
module scd_mod_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_slow,
   output logic o_valid,
   output logic o_bit
);
   // =========================================================
   // sample strobe: squeezed from ~6103 cycles to 2 or 3 so settling fits the run
   logic [1:0] ph_q;
   logic [4:0] pat_q;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ph_q <= 2'h1;
         pat_q <= 5'h00;
      end else begin
         ph_q <= (ph_q == 2'h0) ? (i_slow ? 2'h2 : 2'h1) : ph_q - 2'h1;
         pat_q <= pat_q + {4'h0, ph_q == 2'h0};
      end
   end
   assign o_valid = (ph_q == 2'h0);
   assign o_bit = pat_q[3] ^ pat_q[0];
endmodule
`default_nettype wire

/* File: verification/scd_decimator_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module scd_decimator_properties
   import scd_pkg::*;
#(
   parameter int unsigned RES_W = SCD_RES_W
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_mod_valid,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic o_chop_off,
   input wire logic [RES_W-1:0] o_result,
   input wire logic o_result_valid
);
   // =========================================================
   // shadow word and sample counts since restart and since last result
   logic wdn, rs, um, st_q, st_d, pv_q, pv_d;
   logic [7:0] wd_q, wd_d;
   logic [15:0] cs_q, cs_d, cc_q, cc_d;
   always_comb begin
      wdn = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
      rs = wdn && (i_avs_address == SCD_REG_DEC || i_avs_address == SCD_REG_CTRL);
      um = !(i_avs_address inside {SCD_REG_DEC, SCD_REG_CTRL, SCD_REG_STAT, SCD_REG_RES_LO,
         SCD_REG_RES_HI});
      wd_d = wd_q;
      if (wdn && i_avs_address == SCD_REG_DEC) begin
         wd_d = (i_avs_writedata[7:0] < SCD_DEC_MIN) ? SCD_DEC_MIN : i_avs_writedata[7:0];
      end
      cs_d = rs ? 16'h0 : cs_q + {15'h0, i_mod_valid && cs_q != 16'hffff};
      cc_d = (rs || o_result_valid) ? {15'h0, i_mod_valid} : cc_q + {15'h0, i_mod_valid};
      st_d = rs || (st_q && !o_result_valid);
      pv_d = !rs && (pv_q || o_result_valid);
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         {st_q, pv_q, cs_q, cc_q} <= '0;
         wd_q <= SCD_DEC_RST;
      end else begin
         {st_q, pv_q, cs_q, cc_q} <= {st_d, pv_d, cs_d, cc_d};
         wd_q <= wd_d;
      end
   end
   // =========================================================
   // properties
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   sequence s_rd_done;
      i_avs_read && !o_avs_waitrequest;
   endsequence
   property p_wait;
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("waitrequest longer than one cycle");
   property p_dec_rd;
      s_rd_done ##0 (i_avs_address == SCD_REG_DEC) |-> o_avs_readdata == {24'h0, wd_q};
   endproperty
   a_dec_rd: assert property (p_dec_rd) else $error("decimation word readback wrong");
   property p_unmap;
      s_rd_done ##0 um |-> o_avs_readdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_pulse;
      o_result_valid |=> !o_result_valid;
   endproperty
   a_pulse: assert property (p_pulse) else $error("result valid wider than one cycle");
   property p_hold;
      $changed(o_result) |-> o_result_valid;
   endproperty
   a_hold: assert property (p_hold) else $error("result moved without valid");
   property p_settle;
      st_q && o_result_valid |-> int'(cs_q) >= 24 * int'(wd_q) - 1;
   endproperty
   a_settle: assert property (p_settle) else $error("unsettled result released");
   property p_late;
      st_q && o_chop_off |-> int'(cs_q) <= 24 * int'(wd_q) + 3;
   endproperty
   a_late: assert property (p_late) else $error("settled result overdue");
   property p_period;
      pv_q && o_result_valid |-> int'(cc_q) >= 8 * int'(wd_q) - 1 &&
         int'(cc_q) <= 8 * int'(wd_q) + 1;
   endproperty
   a_period: assert property (p_period) else $error("conversion period wrong");
   property p_nochop;
      (!o_chop_off) [*3] |-> !o_result_valid;
   endproperty
   a_nochop: assert property (p_nochop) else $error("result while chop path off");
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
   import scd_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic slow = 1'b0;
   logic rq_r = 1'b0;
   logic rq_w = 1'b0;
   logic [4:0] ad = 5'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0] be = 4'h0;
   wire logic mv, mb, wt, chop, rv;
   wire logic [31:0] rdat;
   wire logic [3:0] ch;
   wire logic [SCD_RES_W-1:0] res;
   int err_total = 0;
   int n_tests = 0;
   int n;
   logic [31:0] d;
   logic v;
   always #2.5 i_clk = ~i_clk;
   scd_mod_model u_mod (.i_clk, .i_rst, .i_slow(slow), .o_valid(mv), .o_bit(mb));
   scd_decimator dut (.i_clk, .i_rst, .i_mod_valid(mv), .i_mod_bit(mb), .i_avs_address(ad),
      .i_avs_read(rq_r), .i_avs_write(rq_w), .i_avs_writedata(wdat), .i_avs_byteenable(be),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .o_channel(ch), .o_chop_off(chop),
      .o_result(res), .o_result_valid(rv));
   // =========================================================
   // bus and compare tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] dt, input logic [3:0] b);
      @(posedge i_clk);
      ad <= a;
      wdat <= dt;
      be <= b;
      rq_w <= 1'b1;
      do @(posedge i_clk); while (wt !== 1'b0);
      rq_w <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] q);
      @(posedge i_clk);
      ad <= a;
      rq_r <= 1'b1;
      do @(posedge i_clk); while (wt !== 1'b0);
      q = rdat;
      rq_r <= 1'b0;
   endtask
   // counts samples up to and including the next released result
   task automatic conv(input int lim, output int k, output logic vv);
      k = 0;
      do begin
         @(negedge i_clk);
         k += int'(mv);
      end while (rv !== 1'b1 && k < lim);
      vv = rv;
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // =========================================================
   // tests
   initial begin
      repeat (16) @(posedge i_clk);
      // no gain range exists here, so the stimulus never owes an offset calibration
      i_rst <= 1'b0;
      rd(SCD_REG_DEC, d);
      chk("dec_reset", 32'h45, d);
      rd(SCD_REG_CTRL, d);
      chk("ctrl_reset", 32'h1, d);
      wr(5'h14, 32'hff, 4'hf);
      rd(5'h14, d);
      chk("unmapped", 32'h0, d);
      wr(SCD_REG_DEC, 32'hff, 4'h1);
      rd(SCD_REG_DEC, d);
      chk("dec_max", 32'hff, d);
      wr(SCD_REG_DEC, 32'h2, 4'hf);
      rd(SCD_REG_DEC, d);
      chk("dec_clamp", 32'h3, d);
      wr(SCD_REG_DEC, 32'h7, 4'he);
      rd(SCD_REG_DEC, d);
      chk("dec_lane", 32'h3, d);
      for (int w = 3; w <= 4; w++) begin
         slow <= (w == 4);
         wr(SCD_REG_DEC, 32'(w), 4'h1);
         conv(2000, n, v);
         chk("settle", 32'h1, 32'(n >= 24 * w - 1 && n <= 24 * w + 3));
         conv(2000, n, v);
         chk("period", 32'(8 * w), 32'(n));
         repeat (3) conv(2000, n, v);
         rd(SCD_REG_STAT, d);
         chk("status", 32'h47, d & 32'h77);
         rd(SCD_REG_RES_LO, d);
         // the model's bits repeat every 16 samples, half of them ones, so an even
         // word gives a settled sinc3 sum of (4w)*(8w)*(8w)
         if (w == 4) begin
            chk("result_lo", 32'((4 * w) * (8 * w) * (8 * w)), d);
         end
         rd(SCD_REG_STAT, d);
         chk("ready_clear", 32'h0, d & 32'h1);
         // (8w)^3 stays far below 2^32 for these words
         rd(SCD_REG_RES_HI, d);
         chk("result_hi", 32'h0, d);
      end
      wr(SCD_REG_CTRL, 32'h51, 4'h1);
      // the channel register is launched by the completing edge: look mid-cycle
      @(negedge i_clk);
      chk("channel", 32'h5, 32'(ch));
      conv(2000, n, v);
      chk("chan_settle", 32'h1, 32'(n >= 95 && n <= 99));
      wr(SCD_REG_CTRL, 32'h50, 4'h1);
      conv(300, n, v);
      chk("chop_idle", 32'h0, 32'(v));
      chk("chop_pin", 32'h0, 32'(chop));
      give_verdict();
   end
   // tests need about 2300 cycles; more than eight-fold margin
   initial begin
      #100000;
      err_total++;
      give_verdict();
   end
endmodule
bind scd_decimator scd_decimator_properties #(.RES_W(RES_W)) u_chk (.i_clk, .i_rst,
   .i_mod_valid, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
   .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_chop_off, .o_result,
   .o_result_valid);
`default_nettype wire
